// ==== hdl/dpm_pkg.sv ====
package dpm_pkg;
	// table geometry
	localparam int PORTS = 53;
	localparam int PGT_DEPTH = 1077;
	localparam int UNITS = 32;
	localparam int SRC_DEPTH = 89;
	localparam int AGGR_DEPTH = 16;
	localparam int GROUPS = 32;
	localparam logic [10:0] FRONT_LAST = 11'h034;
	localparam logic [10:0] FLOOD_BASE = 11'h035;
	localparam logic [10:0] MC_OFFSET = 11'h035;
	localparam logic [10:0] GLOBAL_AGGREGATION_GROUP_BASE = 11'h335;
	localparam logic [10:0] GLOBAL_AGGREGATION_GROUP_LAST = 11'h434;
	localparam logic [6:0] SRC_GLOBAL_AGGREGATION_GROUP_BASE = 7'h39;
	localparam logic [2:0] FLOOD_LAST = 3'h5;
	// classifier mask modes
	localparam logic [2:0] MODE_REPLACE = 3'h1;
	localparam logic [2:0] MODE_REDIRECT = 3'h4;
	// sticky event positions; flood types 0..5 map straight onto 0..5
	localparam int EV_CPU = 6;
	localparam int EV_NOFWD = 7;
	// apb byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STICKY = 8'h04;
	localparam logic [7:0] REG_CNT_MASK = 8'h08;
	localparam logic [7:0] REG_TBL_ADDR = 8'h0C;
	localparam logic [7:0] REG_DATA0 = 8'h10;
	localparam logic [7:0] REG_DATA1 = 8'h14;
	localparam logic [7:0] REG_DATA2 = 8'h18;
	localparam logic [7:0] REG_TBL_CMD = 8'h1C;
	// field positions
	localparam int CTRL_GLOBAL_AGGREGATION_GROUP_BIT = 0;
	localparam int CTRL_UNIT_LSB = 4;
	localparam int ADDR_TBL_LSB = 12;
	localparam int CMD_WR_BIT = 0;
	localparam int CMD_RD_BIT = 1;
	localparam int D2_QUEUE_LSB = 4;
	localparam int ENC_UNIT_LSB = 6;
	// table selectors for indirect access
	localparam logic [2:0] TBL_PGT = 3'h0;
	localparam logic [2:0] TBL_UNIT = 3'h1;
	localparam logic [2:0] TBL_SRC = 3'h2;
	localparam logic [2:0] TBL_AGGR = 3'h3;
	localparam logic [2:0] TBL_MBR = 3'h4;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {DPM_FLOOD = 2'b00, DPM_UNICAST = 2'b01, DPM_MULTICAST = 2'b10} dpm_kind_t;

	typedef struct packed {
		logic [2:0] cpu_copy_queue;
		logic cpu_copy_enable;
		logic stack;
		logic [52:0] mask;
	} dpm_entry_t;

	typedef struct packed {
		logic valid;
		logic layer2_forward_flag;
		logic routed;
		dpm_kind_t kind;
		logic [2:0] flood_type;
		logic [4:0] stack_unit_id;
		logic [5:0] stack_unit_port;
		logic [9:0] multicast_index;
		logic global_aggregation_group_dest;
		logic [4:0] global_aggregation_group_group;
		logic [2:0] mask_mode;
		logic [52:0] port_mask;
		logic [5:0] src_port;
		logic src_global_aggregation_group_valid;
		logic [4:0] src_global_aggregation_group;
		logic [3:0] aggregation_hash_code;
	} dpm_req_t;

	typedef struct packed {
		logic valid;
		logic [52:0] mask;
		logic cpu_copy_enable;
		logic [2:0] cpu_copy_queue;
	} dpm_res_t;
endpackage

// ==== hdl/dpm_top.sv ====
`timescale 1ns/10ps
module dpm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dpm_pkg::dpm_req_t req,
	output dpm_pkg::dpm_res_t res,
	output logic [7:0] event_count
);
	// lookup tables; no reset, software loads them before traffic
	dpm_pkg::dpm_entry_t port_group_table [dpm_pkg::PGT_DEPTH];
	logic [52:0] per_unit_dest_entry [dpm_pkg::UNITS];
	logic [52:0] source_filter_mask [dpm_pkg::SRC_DEPTH];
	logic [52:0] aggregation_mask_entry [dpm_pkg::AGGR_DEPTH];
	logic [3:0] group_member_count [dpm_pkg::GROUPS];

	logic global_aggr_enable, next_global_aggr_enable;
	logic [4:0] local_unit_id, next_local_unit_id;
	logic [7:0] sticky, next_sticky;
	logic [7:0] count_mask, next_count_mask;
	logic [14:0] tbl_addr, next_tbl_addr;
	logic [31:0] data0, next_data0;
	logic [31:0] data1, next_data1;
	logic [31:0] data2, next_data2;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic acc, wr, hit, tbl_ok, tbl_wr, tbl_rd;
	logic [2:0] tbl_sel;
	logic [10:0] tbl_idx;
	dpm_pkg::dpm_entry_t wr_entry;

	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign tbl_sel = tbl_addr[dpm_pkg::ADDR_TBL_LSB +: 3];
	assign tbl_idx = tbl_addr[10:0];
	assign tbl_wr = wr & (paddr == dpm_pkg::REG_TBL_CMD) & pwdata[dpm_pkg::CMD_WR_BIT] & tbl_ok;
	assign tbl_rd = wr & (paddr == dpm_pkg::REG_TBL_CMD) & pwdata[dpm_pkg::CMD_RD_BIT] & tbl_ok;
	assign wr_entry = {data2[dpm_pkg::D2_QUEUE_LSB +: 3], data2[1], data2[0], data1[20:0], data0};

	// index range check per table; out-of-range commands are dropped
	always_comb begin
		unique case (tbl_sel)
			dpm_pkg::TBL_PGT: tbl_ok = tbl_idx <= dpm_pkg::GLOBAL_AGGREGATION_GROUP_LAST;
			dpm_pkg::TBL_UNIT: tbl_ok = tbl_idx < 11'(dpm_pkg::UNITS);
			dpm_pkg::TBL_SRC: tbl_ok = tbl_idx < 11'(dpm_pkg::SRC_DEPTH);
			dpm_pkg::TBL_AGGR: tbl_ok = tbl_idx < 11'(dpm_pkg::AGGR_DEPTH);
			dpm_pkg::TBL_MBR: tbl_ok = tbl_idx < 11'(dpm_pkg::GROUPS);
			default: tbl_ok = 1'b0;
		endcase
	end

	// table writes; entry control bits kept with the mask in the port group table only
	always_ff @(posedge pclk) begin
		if (tbl_wr) begin
			unique case (tbl_sel)
				dpm_pkg::TBL_PGT: port_group_table[tbl_idx] <= wr_entry;
				dpm_pkg::TBL_UNIT: per_unit_dest_entry[tbl_idx[4:0]] <= wr_entry.mask;
				dpm_pkg::TBL_SRC: source_filter_mask[tbl_idx[6:0]] <= wr_entry.mask;
				dpm_pkg::TBL_AGGR: aggregation_mask_entry[tbl_idx[3:0]] <= wr_entry.mask;
				default: group_member_count[tbl_idx[4:0]] <= data0[3:0];
			endcase
		end
	end

	// forwarding lookup, all combinational into the result flops
	logic [10:0] pg_idx;
	logic use_pgt, skip_src;
	logic [2:0] member;
	dpm_pkg::dpm_entry_t pg_ent;
	logic [52:0] dest, src_m, gsrc_m, aggr_m;
	logic cpu_en;
	logic [7:0] ev;
	dpm_pkg::dpm_res_t next_res;
	logic [7:0] next_event_count;

	assign pg_ent = port_group_table[pg_idx];
	assign member = (group_member_count[req.global_aggregation_group_group] == 4'h0) ? 3'h0
		: 3'(4'(req.aggregation_hash_code[2:0]) % group_member_count[req.global_aggregation_group_group]);

	always_comb begin
		pg_idx = 11'h000;
		use_pgt = 1'b1;
		unique case (req.kind)
			dpm_pkg::DPM_FLOOD: pg_idx = dpm_pkg::FLOOD_BASE + 11'(req.flood_type);
			dpm_pkg::DPM_MULTICAST: pg_idx = dpm_pkg::MC_OFFSET + 11'(req.multicast_index);
			default: begin
				if (req.global_aggregation_group_dest && global_aggr_enable) begin
					pg_idx = dpm_pkg::GLOBAL_AGGREGATION_GROUP_BASE + 11'({req.global_aggregation_group_group, member});
				end else if (req.stack_unit_id == local_unit_id) begin
					pg_idx = 11'(req.stack_unit_port);
				end else begin
					use_pgt = 1'b0;
				end
			end
		endcase
	end

	// destination selection, discard and replace take priority over tables
	always_comb begin
		dest = '0;
		cpu_en = 1'b0;
		ev = 8'h00;
		if (!req.layer2_forward_flag) begin
			ev[dpm_pkg::EV_NOFWD] = 1'b1;
		end else if (req.mask_mode == dpm_pkg::MODE_REPLACE) begin
			dest = req.port_mask;
		end else begin
			if (!use_pgt) begin
				dest = per_unit_dest_entry[req.stack_unit_id];
			end else if (req.kind == dpm_pkg::DPM_UNICAST && !(req.global_aggregation_group_dest && global_aggr_enable)
				&& pg_idx > dpm_pkg::FRONT_LAST) begin
				dest = '0; // ports past the front range do not exist
			end else begin
				if (pg_ent.stack) begin
					dest = per_unit_dest_entry[pg_ent.mask[dpm_pkg::ENC_UNIT_LSB +: 5]];
				end else begin
					dest = pg_ent.mask;
				end
				cpu_en = pg_ent.cpu_copy_enable;
			end
			if (req.kind == dpm_pkg::DPM_FLOOD && req.flood_type <= dpm_pkg::FLOOD_LAST) begin
				ev[req.flood_type] = 1'b1;
			end
			ev[dpm_pkg::EV_CPU] = cpu_en;
		end
	end

	// masks that restrict the selection; routed or redirected frames skip source filters
	always_comb begin
		skip_src = req.routed || req.mask_mode == dpm_pkg::MODE_REDIRECT;
		src_m = skip_src ? '1 : source_filter_mask[7'(req.src_port)];
		gsrc_m = (skip_src || !req.src_global_aggregation_group_valid) ? '1
			: source_filter_mask[dpm_pkg::SRC_GLOBAL_AGGREGATION_GROUP_BASE + 7'(req.src_global_aggregation_group)];
		aggr_m = aggregation_mask_entry[req.aggregation_hash_code];
		next_res.valid = req.valid;
		next_res.mask = req.valid ? (dest & src_m & gsrc_m & aggr_m) : '0;
		next_res.cpu_copy_enable = req.valid & cpu_en;
		next_res.cpu_copy_queue = (req.valid & cpu_en) ? pg_ent.cpu_copy_queue : 3'h0;
		next_event_count = req.valid ? (ev & count_mask) : 8'h00;
	end

	// register file next values; a new event beats a clear in the same cycle
	always_comb begin
		next_global_aggr_enable = global_aggr_enable;
		next_local_unit_id = local_unit_id;
		next_count_mask = count_mask;
		next_tbl_addr = tbl_addr;
		next_data0 = data0;
		next_data1 = data1;
		next_data2 = data2;
		next_sticky = sticky;
		if (wr) begin
			unique case (paddr)
				dpm_pkg::REG_CTRL: begin
					next_global_aggr_enable = pwdata[dpm_pkg::CTRL_GLOBAL_AGGREGATION_GROUP_BIT];
					next_local_unit_id = pwdata[dpm_pkg::CTRL_UNIT_LSB +: 5];
				end
				dpm_pkg::REG_STICKY: next_sticky = sticky & ~pwdata[7:0];
				dpm_pkg::REG_CNT_MASK: next_count_mask = pwdata[7:0];
				dpm_pkg::REG_TBL_ADDR: next_tbl_addr = pwdata[14:0];
				dpm_pkg::REG_DATA0: next_data0 = pwdata;
				dpm_pkg::REG_DATA1: next_data1 = {11'h000, pwdata[20:0]};
				dpm_pkg::REG_DATA2: next_data2 = {25'h0, pwdata[6:4], 2'b00, pwdata[1:0]};
				default: ;
			endcase
		end
		if (tbl_rd) begin
			next_data0 = 32'h0;
			next_data1 = 32'h0;
			next_data2 = 32'h0;
			unique case (tbl_sel)
				dpm_pkg::TBL_PGT: begin
					next_data0 = port_group_table[tbl_idx].mask[31:0];
					next_data1 = {11'h000, port_group_table[tbl_idx].mask[52:32]};
					next_data2 = {25'h0, port_group_table[tbl_idx].cpu_copy_queue, 2'b00,
						port_group_table[tbl_idx].cpu_copy_enable, port_group_table[tbl_idx].stack};
				end
				dpm_pkg::TBL_UNIT: {next_data1[20:0], next_data0} = per_unit_dest_entry[tbl_idx[4:0]];
				dpm_pkg::TBL_SRC: {next_data1[20:0], next_data0} = source_filter_mask[tbl_idx[6:0]];
				dpm_pkg::TBL_AGGR: {next_data1[20:0], next_data0} = aggregation_mask_entry[tbl_idx[3:0]];
				default: next_data0[3:0] = group_member_count[tbl_idx[4:0]];
			endcase
		end
		next_sticky = next_sticky | (req.valid ? ev : 8'h00);
	end

	// apb answer: one wait state, data and ready leave flops together
	always_comb begin
		next_pready = psel & penable & ~pready;
		hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'b00;
		next_pslverr = next_pready & ~hit;
		next_prdata = 32'h0;
		if (next_pready && !pwrite) begin
			unique case (paddr)
				dpm_pkg::REG_CTRL: next_prdata = {27'h0, local_unit_id} << dpm_pkg::CTRL_UNIT_LSB
					| {31'h0, global_aggr_enable};
				dpm_pkg::REG_STICKY: next_prdata = {24'h0, sticky};
				dpm_pkg::REG_CNT_MASK: next_prdata = {24'h0, count_mask};
				dpm_pkg::REG_TBL_ADDR: next_prdata = {17'h0, tbl_addr};
				dpm_pkg::REG_DATA0: next_prdata = data0;
				dpm_pkg::REG_DATA1: next_prdata = data1;
				dpm_pkg::REG_DATA2: next_prdata = data2;
				default: next_prdata = 32'h0;
			endcase
		end
	end

	// all state and outputs except the lookup tables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_aggr_enable <= 1'b0;
			local_unit_id <= 5'h00;
			sticky <= 8'h00;
			count_mask <= 8'h00;
			tbl_addr <= 15'h0000;
			data0 <= dpm_pkg::RESET_WORD;
			data1 <= dpm_pkg::RESET_WORD;
			data2 <= dpm_pkg::RESET_WORD;
			prdata <= dpm_pkg::RESET_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
			res <= '0;
			event_count <= 8'h00;
		end else begin
			global_aggr_enable <= next_global_aggr_enable;
			local_unit_id <= next_local_unit_id;
			sticky <= next_sticky;
			count_mask <= next_count_mask;
			tbl_addr <= next_tbl_addr;
			data0 <= next_data0;
			data1 <= next_data1;
			data2 <= next_data2;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			res <= next_res;
			event_count <= next_event_count;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_DISCARD: assert property (req.valid && !req.layer2_forward_flag |=> res.valid && res.mask == '0
		&& !res.cpu_copy_enable && sticky[dpm_pkg::EV_NOFWD])
		else $error("discarded frame still forwarded");
	AST_REPLACE: assert property (req.valid && req.layer2_forward_flag && req.mask_mode == dpm_pkg::MODE_REPLACE
		|=> (res.mask & ~$past(req.port_mask)) == '0 && !res.cpu_copy_enable)
		else $error("replace mode left classifier mask");
	AST_SRC_FILTER: assert property (req.valid && !skip_src |=> (res.mask & ~$past(src_m & gsrc_m)) == '0)
		else $error("source filter not applied");
	AST_ROUTED: assert property (req.routed |-> src_m == '1 && gsrc_m == '1)
		else $error("routed frame source filtered");
	AST_AGGR: assert property (req.valid |=> (res.mask & ~$past(aggr_m)) == '0)
		else $error("aggregation mask ignored");
	AST_UC_FLOOD: assert property (req.valid && req.layer2_forward_flag && req.mask_mode != dpm_pkg::MODE_REPLACE
		&& req.kind == dpm_pkg::DPM_FLOOD && req.flood_type == 3'h0 |=> sticky[0])
		else $error("unicast flood event missed");
	AST_STICKY_HOLD: assert property (!(wr && paddr == dpm_pkg::REG_STICKY) |=> (sticky & $past(sticky)) == $past(sticky))
		else $error("sticky flag lost");
	AST_COUNT: assert property (event_count != 8'h00 |-> (event_count & ~count_mask) == 8'h00
		&& (event_count & ~sticky) == 8'h00)
		else $error("event count outside mask");
	AST_GLOBAL_AGGREGATION_GROUP_RANGE: assert property (req.valid && req.kind == dpm_pkg::DPM_UNICAST && req.global_aggregation_group_dest
		&& global_aggr_enable
		|-> pg_idx >= dpm_pkg::GLOBAL_AGGREGATION_GROUP_BASE && pg_idx <= dpm_pkg::GLOBAL_AGGREGATION_GROUP_LAST)
		else $error("global aggregation address out of range");
	AST_APB: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	COV_FLOOD: cover property (req.valid && req.kind == dpm_pkg::DPM_FLOOD ##1 res.mask != '0);
	COV_STACKED_MC: cover property (req.valid && req.kind == dpm_pkg::DPM_MULTICAST && pg_ent.stack);
	COV_CPU: cover property (res.cpu_copy_enable);
endmodule // dpm_top

// ==== verif/dpm_req_src.sv ====
`timescale 1ns/10ps
// upstream classifier stand-in: launches one request for each go cycle
module dpm_req_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire dpm_pkg::dpm_req_t cmd,
	output dpm_pkg::dpm_req_t req
);
	dpm_pkg::dpm_req_t next_req;

	// idle cycles show inverted fields, so a stale request never looks valid by luck
	always_comb begin
		next_req = go ? cmd : ~req;
		next_req.valid = go;
	end

	// launch after the edge, like the real pipeline stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req <= '0;
		end else begin
			req <= next_req;
		end
	end
endmodule // dpm_req_src

// ==== verif/destination_port_mask_select_test.sv ====
`timescale 1ns/10ps
module destination_port_mask_select_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
	logic [7:0] paddr, event_count;
	logic [31:0] pwdata, prdata, rd_dummy;
	logic err_dummy;
	dpm_pkg::dpm_req_t req, cmd, r;
	dpm_pkg::dpm_res_t res;
	int mismatches = 0, num_checks = 0, cycles = 0, i;
	localparam logic [52:0] ALL = '1;
	localparam logic [52:0] SRC0 = ALL ^ 53'h1;
	localparam logic [52:0] S57 = ALL ^ 53'h2;
	localparam logic [52:0] A1 = ALL ^ 53'h4;
	localparam logic [52:0] U5 = 53'h1E_0F0F_0F0F_0F0F;
	localparam logic [52:0] P = 53'h15_5555_5555_5555;

	dpm_req_src i_src (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd), .req(req));
	dpm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req(req), .res(res), .event_count(event_count));

	// distinct mask per table entry; low bits set so source and aggregation pruning shows
	function automatic logic [52:0] pm(input int n);
		return {11'(n), 42'h3FF_FFFF_FFFF};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only pready or the bench's cycle ceiling may end this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic aw(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd_dummy, err_dummy);
	endtask

	task automatic ar(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, exp);
		chk(e, experr);
	endtask

	// indirect table write through the address, data and command registers
	task automatic tw(input logic [2:0] t, input logic [10:0] idx, input logic [52:0] m, input logic [7:0] d2);
		aw(dpm_pkg::REG_TBL_ADDR, {17'h0, t, 1'b0, idx});
		aw(dpm_pkg::REG_DATA0, m[31:0]);
		aw(dpm_pkg::REG_DATA1, {11'h0, m[52:32]});
		aw(dpm_pkg::REG_DATA2, {24'h0, d2});
		aw(dpm_pkg::REG_TBL_CMD, 32'h1);
	endtask

	task automatic base();
		r = '0;
		r.layer2_forward_flag = 1'b1;
	endtask

	// the model launches one edge after go, the result stands one edge after that
	task automatic send(input logic [52:0] m, input logic ce, input logic [2:0] q, input logic [7:0] ev);
		@(posedge pclk);
		go <= 1'b1;
		cmd <= r;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1;
		chk({res.valid, res.cpu_copy_enable, res.cpu_copy_queue, res.mask}, {1'b1, ce, q, m});
		chk(event_count, ev);
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, go} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		cmd = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk(res, '0);
		ar(8'h20, 32'h0, 1'b1);
		aw(dpm_pkg::REG_CTRL, 32'h30);
		aw(dpm_pkg::REG_CNT_MASK, 32'hFF);
		ar(dpm_pkg::REG_CNT_MASK, 32'hFF, 1'b0);
		for (i = 53; i <= 60; i++) tw(dpm_pkg::TBL_PGT, 11'(i), pm(i), (i == 60) ? 8'h52 : 8'h00);
		tw(dpm_pkg::TBL_PGT, 11'h3D, 53'h140, 8'h01);
		tw(dpm_pkg::TBL_PGT, 11'h2, pm(2), 8'h00);
		tw(dpm_pkg::TBL_PGT, 11'h336, 53'h140, 8'h01);
		tw(dpm_pkg::TBL_UNIT, 11'h5, U5, 8'h00);
		tw(dpm_pkg::TBL_SRC, 11'h0, SRC0, 8'h00);
		tw(dpm_pkg::TBL_SRC, 11'h39, S57, 8'h00);
		tw(dpm_pkg::TBL_AGGR, 11'h0, ALL, 8'h00);
		tw(dpm_pkg::TBL_AGGR, 11'h1, A1, 8'h00);
		tw(dpm_pkg::TBL_MBR, 11'h0, 53'h2, 8'h00);
		aw(dpm_pkg::REG_TBL_ADDR, 32'h3C);
		aw(dpm_pkg::REG_TBL_CMD, 32'h2);
		ar(dpm_pkg::REG_DATA2, 32'h52, 1'b0);
		for (i = 0; i < 6; i++) begin
			base();
			r.flood_type = 3'(i);
			send(pm(53 + i) & SRC0, 1'b0, 3'h0, 8'h01 << i);
		end
		base();
		r.kind = dpm_pkg::DPM_UNICAST;
		r.stack_unit_id = 5'h3;
		r.stack_unit_port = 6'h2;
		send(pm(2) & SRC0, 1'b0, 3'h0, 8'h00);
		r.stack_unit_id = 5'h5;
		send(U5 & SRC0, 1'b0, 3'h0, 8'h00);
		base();
		r.kind = dpm_pkg::DPM_MULTICAST;
		r.multicast_index = 10'h7;
		send(pm(60) & SRC0, 1'b1, 3'h5, 8'h40);
		r.multicast_index = 10'h8;
		send(U5 & SRC0, 1'b0, 3'h0, 8'h00);
		base();
		r.mask_mode = dpm_pkg::MODE_REPLACE;
		r.port_mask = P;
		send(P & SRC0, 1'b0, 3'h0, 8'h00);
		base();
		r.layer2_forward_flag = 1'b0;
		send(53'h0, 1'b0, 3'h0, 8'h80);
		base();
		r.kind = dpm_pkg::DPM_UNICAST;
		r.stack_unit_id = 5'h3;
		r.stack_unit_port = 6'h2;
		r.mask_mode = dpm_pkg::MODE_REDIRECT;
		send(pm(2), 1'b0, 3'h0, 8'h00);
		r.mask_mode = 3'h0;
		r.routed = 1'b1;
		send(pm(2), 1'b0, 3'h0, 8'h00);
		r.routed = 1'b0;
		r.src_global_aggregation_group_valid = 1'b1;
		send(pm(2) & SRC0 & S57, 1'b0, 3'h0, 8'h00);
		r.src_global_aggregation_group_valid = 1'b0;
		r.aggregation_hash_code = 4'h1;
		send(pm(2) & SRC0 & A1, 1'b0, 3'h0, 8'h00);
		r.global_aggregation_group_dest = 1'b1;
		send(pm(2) & SRC0 & A1, 1'b0, 3'h0, 8'h00);
		aw(dpm_pkg::REG_CTRL, 32'h31);
		send(U5 & SRC0 & A1, 1'b0, 3'h0, 8'h00);
		r.global_aggregation_group_dest = 1'b0;
		r.aggregation_hash_code = 4'h0;
		send(pm(2) & SRC0, 1'b0, 3'h0, 8'h00);
		ar(dpm_pkg::REG_STICKY, 32'hFF, 1'b0);
		aw(dpm_pkg::REG_STICKY, 32'hFF);
		ar(dpm_pkg::REG_STICKY, 32'h0, 1'b0);
		aw(dpm_pkg::REG_CNT_MASK, 32'h01);
		base();
		r.flood_type = 3'h1;
		send(pm(54) & SRC0, 1'b0, 3'h0, 8'h00);
		give_verdict();
	end
endmodule // destination_port_mask_select_test
